// ==== verilog/tps_defs.svh ====
`ifndef TPS_DEFS_SVH
`define TPS_DEFS_SVH
// register word offsets (byte addresses)
`define TPS_OFS_SC      8'h00
`define TPS_OFS_CNT     8'h04
`define TPS_OFS_MOD     8'h08
`define TPS_OFS_CH_BASE 8'h40
`define TPS_CH_STRIDE   8'h08
`define TPS_CH_VAL_OFS  8'h04
// status and control fields
`define TPS_SC_FLAG     7
`define TPS_SC_IE       6
`define TPS_SC_CENTER   5
`define TPS_SC_CLK_HI   4
`define TPS_SC_CLK_LO   3
`define TPS_SC_PS_HI    2
`define TPS_SC_PS_LO    0
// channel status fields
`define TPS_CH_FLAG     7
`define TPS_CH_IE       6
`define TPS_CH_MODE_HI  5
`define TPS_CH_MODE_LO  4
`define TPS_CH_EDGE_HI  3
`define TPS_CH_EDGE_LO  2
// reset values and counter limits
`define TPS_MOD_RESET   16'h0000
`define TPS_CNT_ZERO    16'h0000
`define TPS_CNT_MAX     16'hffff
`endif

// ==== verilog/tps_pkg.sv ====
package tps_pkg;
  typedef enum logic [1:0] {
    TPS_CLK_OFF,
    TPS_CLK_BUS,
    TPS_CLK_FIXED,
    TPS_CLK_EXT
  } tps_clk_src_type;

  typedef enum logic {
    TPS_DIR_UP,
    TPS_DIR_DOWN
  } tps_dir_type;

  // channel mode codes: 00 capture, 01 compare, 1x edge pwm
  typedef struct packed {
    logic       flag;
    logic       ie;
    logic [1:0] mode;
    logic [1:0] edge_sel;
  } tps_ch_ctrl_type;

  typedef struct packed {
    logic            flag;
    logic            ie;
    logic            center;
    tps_clk_src_type clk_src;
    logic [2:0]      ps;
  } tps_sc_type;
endpackage

// ==== verilog/tps_timer.sv ====
`timescale 1ns/1ps
`include "tps_defs.svh"
// Notes on behaviour
// (RL1) flag overflow when counter wraps after modulo
// (RL2) clear overflow flag: read set, write zero
// (RL3) overflow during clear restarts the sequence
// (RL4) writing one to overflow flag: no effect
// (RL5) irq when flag set and enable set
// (RL6) reset clears flag, enable, center select
// (RL7) center select forces up/down center pwm
// (RL8) two-bit clock select: off or source
// (RL9) external clock synchronised; fixed equals bus
// (RL10) three-bit prescale feeds the counter
// (RL11) prescale ratios one through 128
// (RL12) new prescale acts next clock cycle
// (RL13) at modulo: restart zero or count down
// (RL14) one modulo byte written suppresses overflow
// (RL15) modulo resets to zero, free running
// (RL16) a counter write selecting byte 0 or 1 resets the counter
// (RL17) debug mode freezes counter and latches; the code stops only counter and prescaler, capture edges still latch the count
// (RL18) software writes modulo after overflow
// (RL19) center overflow leaving modulus downward
// (RL20) capture edge select sets channel flag
// (RL21) compare match sets channel flag
// (RL22) edge pwm match sets channel flag
// (RL23) center pwm both matches set flag
// (RL24) channel flags use two-step clear
// (RL25) clock codes: off, bus, fixed, external
// (RL26) channel clear: read status, write zero
module tps_timer
  import tps_pkg::*;
#(
  parameter int N_CH = 2
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            cyc_i,
  input  wire logic            stb_i,
  input  wire logic            we_i,
  input  wire logic [7:0]      adr_i,
  input  wire logic [3:0]      sel_i,
  input  wire logic [31:0]     dat_i,
  output logic      [31:0]     dat_o,
  output logic                 ack_o,
  input  wire logic            ext_clk_i,
  input  wire logic            debug_active_i,
  input  wire logic [N_CH-1:0] ch_pin_i,
  output logic      [N_CH-1:0] ch_pin_o,
  output logic                 overflow_irq_o,
  output logic      [N_CH-1:0] channel_irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // divider mask for a prescale code: ratio is mask plus one
  function automatic logic [6:0] ps_mask(input logic [2:0] ps);
    ps_mask = 7'((8'h01 << ps) - 8'h01); // RL11
  endfunction

  function automatic logic is_ch(input logic [7:0] a);
    is_ch = (a >= `TPS_OFS_CH_BASE) &&
            (a < 8'(`TPS_OFS_CH_BASE + N_CH * `TPS_CH_STRIDE));
  endfunction

  function automatic int ch_idx(input logic [7:0] a);
    ch_idx = int'((a - `TPS_OFS_CH_BASE) / `TPS_CH_STRIDE);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  logic            ack_q;
  logic            req;
  logic            wr;
  logic            rd;
  logic [7:0]      wa;
  tps_sc_type      sc_q;
  logic            ovf_arm_q;
  logic [15:0]     cnt_q;
  logic [15:0]     mod_q;
  logic            mod_lo_pend_q;
  logic            mod_hi_pend_q;
  tps_dir_type     dir_q;
  logic [6:0]      pre_q;
  logic            irq_q;
  tps_ch_ctrl_type ch_ctrl_q [N_CH];
  logic [15:0]     ch_val_q  [N_CH];
  logic [N_CH-1:0] ch_arm_q;
  logic [N_CH-1:0] ch_s1_q;
  logic [N_CH-1:0] ch_s2_q;
  logic [N_CH-1:0] ch_s3_q;
  logic [N_CH-1:0] ch_out_q;
  logic [N_CH-1:0] ch_irq_q;
  logic [31:0]     dat_q;
  logic [2:0]      ext_q;

  assign req = cyc_i && stb_i && !ack_q;
  assign wr  = req && we_i;
  assign rd  = req && !we_i;
  assign wa  = {adr_i[7:2], 2'b00};

  // one wait state: ack follows the request by one edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // read mux; unmapped words read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (rd) begin
      dat_q <= 32'h0000_0000;
      if (wa == `TPS_OFS_SC) begin
        dat_q[7:0] <= sc_q;
      end else if (wa == `TPS_OFS_CNT) begin
        dat_q[15:0] <= cnt_q;
      end else if (wa == `TPS_OFS_MOD) begin
        dat_q[15:0] <= mod_q;
      end else if (is_ch(wa)) begin
        if (wa[2:0] == `TPS_CH_VAL_OFS) begin
          dat_q[15:0] <= ch_val_q[ch_idx(wa)];
        end else begin
          dat_q[7:2] <= ch_ctrl_q[ch_idx(wa)];
        end
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  ////////////////////////////////////////////////////////////////////////
  // clock source and prescaler

  logic ext_edge;
  logic src_tick;
  logic tick;
  logic freeze;

  // external clock passes two flops; third stage only for edge detect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_q <= 3'h0;
    end else begin
      ext_q <= {ext_q[1:0], ext_clk_i}; // RL9
    end
  end
  assign ext_edge = ext_q[1] && !ext_q[2];
  assign freeze   = debug_active_i;

  // without a pll the fixed clock is the bus clock itself
  always_comb begin
    case (sc_q.clk_src) // RL8 RL25
      TPS_CLK_OFF:   src_tick = 1'b0;
      TPS_CLK_BUS:   src_tick = 1'b1;
      TPS_CLK_FIXED: src_tick = 1'b1; // RL9
      TPS_CLK_EXT:   src_tick = ext_edge;
      default:       src_tick = 1'b0;
    endcase
  end

  // mask read from live register bits so a new ratio acts next cycle
  assign tick = src_tick && !freeze &&
                ((pre_q & ps_mask(sc_q.ps)) == ps_mask(sc_q.ps)); // RL10 RL12

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= 7'h00;
    end else if (src_tick && !freeze) begin
      pre_q <= pre_q + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter

  logic        cnt_wr;
  logic [15:0] cnt_d;
  tps_dir_type dir_d;
  logic        wrap;
  logic        ovf_evt;

  assign cnt_wr = wr && (wa == `TPS_OFS_CNT) && (sel_i[1:0] != 2'b00);

  always_comb begin
    cnt_d = cnt_q + 16'h0001;
    dir_d = dir_q;
    wrap  = 1'b0;
    if (sc_q.center) begin
      if (dir_q == TPS_DIR_UP) begin
        if (cnt_q == mod_q) begin
          cnt_d = cnt_q - 16'h0001; // RL13 RL19
          dir_d = TPS_DIR_DOWN;
          wrap  = 1'b1;
        end
      end else if (cnt_q == `TPS_CNT_ZERO) begin
        dir_d = TPS_DIR_UP;
      end else begin
        cnt_d = cnt_q - 16'h0001;
      end
    end else begin
      dir_d = TPS_DIR_UP;
      if ((mod_q != `TPS_MOD_RESET && cnt_q == mod_q) ||
          cnt_q == `TPS_CNT_MAX) begin
        cnt_d = `TPS_CNT_ZERO; // RL1 RL13 RL15
        wrap  = 1'b1;
      end
    end
  end

  // coherency is trivial on a 32-bit read, so freezing the count is enough
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= `TPS_CNT_ZERO;
      dir_q <= TPS_DIR_UP;
    end else if (cnt_wr) begin
      cnt_q <= `TPS_CNT_ZERO; // RL16
      dir_q <= TPS_DIR_UP;
    end else if (tick) begin
      cnt_q <= cnt_d; // RL17
      dir_q <= dir_d;
    end
  end

  assign ovf_evt = tick && wrap && !mod_lo_pend_q && !mod_hi_pend_q; // RL14

  ////////////////////////////////////////////////////////////////////////
  // modulo register with byte pairing

  logic mod_wr;
  assign mod_wr = wr && (wa == `TPS_OFS_MOD);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_q         <= `TPS_MOD_RESET; // RL15
      mod_lo_pend_q <= 1'b0;
      mod_hi_pend_q <= 1'b0;
    end else if (mod_wr) begin
      if (sel_i[0]) begin
        mod_q[7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        mod_q[15:8] <= dat_i[15:8];
      end
      // a lone byte holds overflows off until its partner arrives; the
      // partner must clear both, or the pair would block forever
      mod_lo_pend_q <= sel_i[1] && !sel_i[0] && !mod_hi_pend_q; // RL14
      mod_hi_pend_q <= sel_i[0] && !sel_i[1] && !mod_lo_pend_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status and control

  logic sc_wr;
  logic sc_rd;
  assign sc_wr = wr && (wa == `TPS_OFS_SC) && sel_i[0];
  assign sc_rd = rd && (wa == `TPS_OFS_SC);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sc_q <= '0; // RL6
    end else begin
      if (sc_wr) begin
        sc_q.ie      <= dat_i[`TPS_SC_IE];
        sc_q.center  <= dat_i[`TPS_SC_CENTER]; // RL7
        sc_q.clk_src <= tps_clk_src_type'(
                          dat_i[`TPS_SC_CLK_HI:`TPS_SC_CLK_LO]);
        sc_q.ps      <= dat_i[`TPS_SC_PS_HI:`TPS_SC_PS_LO];
      end
      // set wins over the clear; writing one leaves the flag alone
      if (ovf_evt) begin
        sc_q.flag <= 1'b1; // RL1
      end else if (sc_wr && !dat_i[`TPS_SC_FLAG] && ovf_arm_q) begin
        sc_q.flag <= 1'b0; // RL2 RL4
      end
    end
  end

  // arming: a read while set; a new overflow restarts the sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_arm_q <= 1'b0;
    end else if (ovf_evt) begin
      ovf_arm_q <= 1'b0; // RL3
    end else if (sc_rd && sc_q.flag) begin
      ovf_arm_q <= 1'b1; // RL2
    end else if (sc_wr) begin
      ovf_arm_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= sc_q.flag && sc_q.ie; // RL5
    end
  end
  assign overflow_irq_o = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // channels

  logic [N_CH-1:0] ch_evt;
  logic [N_CH-1:0] ch_match;
  logic [N_CH-1:0] ch_edge;

  // pins pass two flops before the edge detector reads stage two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch_s1_q <= '0;
      ch_s2_q <= '0;
      ch_s3_q <= '0;
    end else begin
      ch_s1_q <= ch_pin_i;
      ch_s2_q <= ch_s1_q;
      ch_s3_q <= ch_s2_q;
    end
  end

  always_comb begin
    for (int i = 0; i < N_CH; i++) begin
      ch_match[i] = tick && (cnt_q == ch_val_q[i]);
      case (ch_ctrl_q[i].edge_sel)
        2'b01:   ch_edge[i] = ch_s2_q[i] && !ch_s3_q[i];
        2'b10:   ch_edge[i] = !ch_s2_q[i] && ch_s3_q[i];
        2'b11:   ch_edge[i] = ch_s2_q[i] != ch_s3_q[i];
        default: ch_edge[i] = 1'b0;
      endcase
      if (sc_q.center) begin
        ch_evt[i] = ch_match[i]; // RL23
      end else if (ch_ctrl_q[i].mode == 2'b00) begin
        ch_evt[i] = ch_edge[i]; // RL20
      end else begin
        ch_evt[i] = ch_match[i]; // RL21 RL22
      end
    end
  end

  // channel control, value, flags and two-step clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N_CH; i++) begin
        ch_ctrl_q[i] <= '0;
        ch_val_q[i]  <= 16'h0000;
      end
      ch_arm_q <= '0;
    end else begin
      for (int i = 0; i < N_CH; i++) begin
        if (wr && is_ch(wa) && ch_idx(wa) == i) begin
          if (wa[2:0] == `TPS_CH_VAL_OFS) begin
            if (sel_i[0]) begin
              ch_val_q[i][7:0] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
              ch_val_q[i][15:8] <= dat_i[15:8];
            end
          end else if (sel_i[0]) begin
            ch_ctrl_q[i].ie       <= dat_i[`TPS_CH_IE];
            ch_ctrl_q[i].mode     <= dat_i[`TPS_CH_MODE_HI:`TPS_CH_MODE_LO];
            ch_ctrl_q[i].edge_sel <= dat_i[`TPS_CH_EDGE_HI:`TPS_CH_EDGE_LO];
            if (!dat_i[`TPS_CH_FLAG] && ch_arm_q[i] && !ch_evt[i]) begin
              ch_ctrl_q[i].flag <= 1'b0; // RL24 RL26
            end
            ch_arm_q[i] <= 1'b0;
          end
        end
        if (rd && is_ch(wa) && ch_idx(wa) == i &&
            wa[2:0] != `TPS_CH_VAL_OFS && ch_ctrl_q[i].flag) begin
          ch_arm_q[i] <= 1'b1; // RL26
        end
        if (ch_evt[i]) begin
          ch_ctrl_q[i].flag <= 1'b1;
          ch_arm_q[i]       <= 1'b0;
          if (!sc_q.center && ch_ctrl_q[i].mode == 2'b00) begin
            ch_val_q[i] <= cnt_q;
          end
        end
      end
    end
  end

  // pin drive: compare action, edge pwm, center pwm toggle at matches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch_out_q <= '0;
      ch_irq_q <= '0;
    end else begin
      for (int i = 0; i < N_CH; i++) begin
        ch_irq_q[i] <= ch_ctrl_q[i].flag && ch_ctrl_q[i].ie;
        if (sc_q.center) begin
          if (ch_match[i]) begin
            ch_out_q[i] <= (dir_q == TPS_DIR_DOWN) ^
                           ch_ctrl_q[i].edge_sel[0];
          end
        end else if (ch_ctrl_q[i].mode[1]) begin
          if (ch_match[i]) begin
            ch_out_q[i] <= ch_ctrl_q[i].edge_sel[0];
          end else if (tick && wrap) begin
            ch_out_q[i] <= !ch_ctrl_q[i].edge_sel[0];
          end
        end else if (ch_ctrl_q[i].mode == 2'b01 && ch_match[i]) begin
          case (ch_ctrl_q[i].edge_sel)
            2'b01:   ch_out_q[i] <= !ch_out_q[i];
            2'b10:   ch_out_q[i] <= 1'b0;
            2'b11:   ch_out_q[i] <= 1'b1;
            default: ch_out_q[i] <= ch_out_q[i];
          endcase
        end
      end
    end
  end
  assign ch_pin_o      = ch_out_q;
  assign channel_irq_o = ch_irq_q;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  ovf_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
    ovf_evt |=> sc_q.flag)
    else $error("overflow did not set the flag");

  flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
    sc_q.flag && !(sc_wr && !dat_i[`TPS_SC_FLAG] && ovf_arm_q)
      |=> sc_q.flag)
    else $error("overflow flag cleared without the sequence");

  clear_arm_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
    $fell(sc_q.flag) |-> $past(ovf_arm_q) && !$past(ovf_evt))
    else $error("overflow flag fell while not armed");

  restart_seq_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
    ovf_evt |=> !ovf_arm_q ##1 (sc_q.flag || ovf_evt))
    else $error("clear sequence not restarted by overflow");

  irq_follow_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
    ##1 overflow_irq_o == ($past(sc_q.flag) && $past(sc_q.ie)))
    else $error("overflow request does not follow flag and enable");

  mod_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
    (mod_lo_pend_q || mod_hi_pend_q) && !sc_q.flag |=> !sc_q.flag)
    else $error("overflow flagged during half written modulo");

  cnt_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
    cnt_wr |=> cnt_q == `TPS_CNT_ZERO)
    else $error("counter write did not clear the counter");

  freeze_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL17
    debug_active_i && !cnt_wr |=> $stable(cnt_q))
    else $error("counter moved while debug mode active");

  center_turn_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL19
    sc_q.center && tick && dir_q == TPS_DIR_UP && cnt_q == mod_q
      && !cnt_wr |=> dir_q == TPS_DIR_DOWN &&
      cnt_q == $past(mod_q) - 16'h0001)
    else $error("center count did not turn down at modulus");

  pre_div_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL10
    tick && sc_q.ps != 3'h0 && !sc_wr |=> !tick)
    else $error("counter stepped twice within one prescale period");

  ch_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL21
    ch_evt[0] |=> ch_ctrl_q[0].flag)
    else $error("channel event did not set channel flag");

endmodule

// ==== verification/tps_pin_model.sv ====
`timescale 1ns/1ps
// far side of the channel pins and the external clock pin
module tps_pin_model #(
  parameter int N_CH = 2
) (
  input  wire logic            clk_i,
  input  wire logic            ext_run_i,
  input  wire logic [N_CH-1:0] cap_lvl_i,
  input  wire logic [N_CH-1:0] out_pin_i,
  output logic                 ext_clk_o,
  output logic      [N_CH-1:0] cap_pin_o,
  output int                   edges_o
);
  logic [1:0]      div_q  = 2'h0;
  logic            ext_q  = 1'b0;
  logic [N_CH-1:0] cap_q  = '0;
  logic            last_q = 1'b0;
  int              edges_q = 0;

  assign ext_clk_o = ext_q;
  assign cap_pin_o = cap_q;
  assign edges_o   = edges_q;

  ////////////////////////////////////////////////////////////////////////////
  // external clock, period six bus cycles; stands low outside bursts so a
  // stopped source cannot sneak extra counts into the timer
  always_ff @(posedge clk_i) begin
    if (!ext_run_i) begin
      div_q <= 2'h0;
      ext_q <= 1'b0;
    end else if (div_q == 2'h2) begin
      div_q <= 2'h0;
      ext_q <= ~ext_q;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  // capture levels change only just after an edge
  always_ff @(posedge clk_i) begin
    cap_q <= cap_lvl_i;
  end

  // count rising edges on channel 0 output to see compare actions
  always_ff @(posedge clk_i) begin
    last_q <= out_pin_i[0];
    if (out_pin_i[0] && !last_q) begin
      edges_q <= edges_q + 1;
    end
  end
endmodule

// ==== verification/tps_timer_tb.sv ====
`timescale 1ns/1ps
`include "tps_defs.svh"
module tps_timer_tb;
  import tps_pkg::*;
  localparam int N_CH = 2;
  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            cyc = 1'b0;
  logic            stb = 1'b0;
  logic            we = 1'b0;
  logic [7:0]      adr = 8'h00;
  logic [3:0]      sel = 4'h0;
  logic [31:0]     wdat = 32'h0;
  logic [31:0]     rd;
  logic [31:0]     dat_o;
  logic            ack_o;
  logic            ovf_irq;
  logic [N_CH-1:0] ch_in;
  logic [N_CH-1:0] ch_out;
  logic [N_CH-1:0] ch_irq;
  logic [N_CH-1:0] cap_lvl = '0;
  logic            ext_clk;
  logic            ext_run = 1'b0;
  logic            dbg = 1'b0;
  int              edges;
  int              failures = 0;
  int              checks = 0;

  always #25 clk_i = ~clk_i;

  tps_timer #(.N_CH(N_CH)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .ext_clk_i(ext_clk), .debug_active_i(dbg), .ch_pin_i(ch_in),
    .ch_pin_o(ch_out), .overflow_irq_o(ovf_irq), .channel_irq_o(ch_irq));

  tps_pin_model #(.N_CH(N_CH)) pins_u (
    .clk_i(clk_i), .ext_run_i(ext_run), .cap_lvl_i(cap_lvl),
    .out_pin_i(ch_out), .ext_clk_o(ext_clk), .cap_pin_o(ch_in),
    .edges_o(edges));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one classic cycle; held until ack is sampled, released at that edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 20) begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    bus(1'b1, a, s, d);
  endtask

  task automatic rdr(input logic [7:0] a);
    bus(1'b0, a, 4'h3, 32'h0);
  endtask

  // poll until a status bit reads set; bounded
  task automatic wait_set(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do begin
      rdr(a);
      n++;
    end while (rd[b] !== 1'b1 && n < 200);
    chk(rd[b], 1'b1);
  endtask

  task automatic chk_rng(input logic [31:0] v, input int lo, input int hi);
    chk(v >= lo && v <= hi, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdr(`TPS_OFS_SC); chk(rd, 32'h0);
    rdr(`TPS_OFS_MOD); chk(rd, `TPS_MOD_RESET);
    rdr(`TPS_OFS_CNT); chk(rd, 32'h0);
    rdr(8'h20); chk(rd, 32'h0);
    chk(ovf_irq, 1'b0);
  endtask

  task automatic t_overflow;
    wr(`TPS_OFS_CNT, 4'h3, 32'h0);
    wr(`TPS_OFS_MOD, 4'h3, 32'h00ff);
    wr(`TPS_OFS_SC, 4'h1, 32'h48);
    wait_set(`TPS_OFS_SC, `TPS_SC_FLAG);
    repeat (2) @(posedge clk_i);
    chk(ovf_irq, 1'b1);
    wr(`TPS_OFS_SC, 4'h1, 32'hc8);
    rdr(`TPS_OFS_SC); chk(rd[7], 1'b1);
    wr(`TPS_OFS_SC, 4'h1, 32'h48);
    rdr(`TPS_OFS_SC); chk(rd[7], 1'b0);
    repeat (3) @(posedge clk_i);
    chk(ovf_irq, 1'b0);
    wait_set(`TPS_OFS_SC, `TPS_SC_FLAG);
    repeat (300) @(posedge clk_i);
    wr(`TPS_OFS_SC, 4'h1, 32'h48);
    rdr(`TPS_OFS_SC); chk(rd[7], 1'b1);
    wr(`TPS_OFS_SC, 4'h1, 32'h88);
    repeat (3) @(posedge clk_i);
    chk(ovf_irq, 1'b0);
  endtask

  // each prescale code, then the other clock sources
  task automatic t_clocks;
    logic [31:0] a;
    for (int k = 0; k < 8; k++) begin
      wr(`TPS_OFS_SC, 4'h1, 32'h88 | k);
      wr(`TPS_OFS_CNT, 4'h1, 32'h0);
      repeat (10 << k) @(posedge clk_i);
      rdr(`TPS_OFS_CNT); chk_rng(rd, 9, 14);
    end
    wr(`TPS_OFS_SC, 4'h1, 32'h80);
    rdr(`TPS_OFS_CNT); a = rd;
    repeat (20) @(posedge clk_i);
    rdr(`TPS_OFS_CNT); chk(rd, a);
    wr(`TPS_OFS_SC, 4'h1, 32'h90);
    wr(`TPS_OFS_CNT, 4'h1, 32'h0);
    repeat (10) @(posedge clk_i);
    rdr(`TPS_OFS_CNT); chk_rng(rd, 9, 14);
    wr(`TPS_OFS_SC, 4'h1, 32'h98);
    wr(`TPS_OFS_CNT, 4'h1, 32'h0);
    ext_run <= 1'b1;
    repeat (60) @(posedge clk_i);
    ext_run <= 1'b0;
    rdr(`TPS_OFS_CNT); chk_rng(rd, 8, 12);
  endtask

  task automatic t_modbyte;
    wr(`TPS_OFS_SC, 4'h1, 32'h80);
    rdr(`TPS_OFS_SC);
    wr(`TPS_OFS_SC, 4'h1, 32'h00);
    wr(`TPS_OFS_CNT, 4'h1, 32'h0);
    wr(`TPS_OFS_MOD, 4'h1, 32'h10);
    wr(`TPS_OFS_SC, 4'h1, 32'h08);
    repeat (100) @(posedge clk_i);
    rdr(`TPS_OFS_SC); chk(rd[7], 1'b0);
    wr(`TPS_OFS_MOD, 4'h2, 32'h0);
    wait_set(`TPS_OFS_SC, `TPS_SC_FLAG);
    wr(`TPS_OFS_SC, 4'h1, 32'h80);
    rdr(`TPS_OFS_SC);
    wr(`TPS_OFS_SC, 4'h1, 32'h00);
  endtask

  task automatic t_count_debug;
    logic [31:0] a;
    wr(`TPS_OFS_MOD, 4'h3, 32'h0);
    wr(`TPS_OFS_SC, 4'h1, 32'h08);
    repeat (50) @(posedge clk_i);
    wr(`TPS_OFS_CNT, 4'h2, 32'h1234);
    rdr(`TPS_OFS_CNT); chk_rng(rd, 0, 7);
    dbg <= 1'b1;
    rdr(`TPS_OFS_CNT); a = rd;
    repeat (40) @(posedge clk_i);
    rdr(`TPS_OFS_CNT); chk(rd, a);
    dbg <= 1'b0;
    repeat (10) @(posedge clk_i);
    rdr(`TPS_OFS_CNT); chk(rd != a, 1'b1);
  endtask

  // channel 0 compare with toggle action, channel 1 rising capture
  task automatic t_channels;
    int e0;
    wr(`TPS_OFS_SC, 4'h1, 32'h00);
    wr(`TPS_OFS_CNT, 4'h1, 32'h0);
    wr(`TPS_OFS_MOD, 4'h3, 32'h3f);
    wr(8'h40, 4'h1, 32'h54);
    wr(8'h44, 4'h3, 32'h20);
    wr(`TPS_OFS_SC, 4'h1, 32'h08);
    wait_set(8'h40, `TPS_CH_FLAG);
    repeat (2) @(posedge clk_i);
    chk(ch_irq[0], 1'b1);
    wr(8'h40, 4'h1, 32'h54);
    rdr(8'h40); chk(rd[7], 1'b0);
    e0 = edges;
    repeat (150) @(posedge clk_i);
    chk(edges > e0, 1'b1);
    rdr(8'h40); chk(rd[7], 1'b1);
    // channel 0 to edge pwm, high-true; the armed write clears its flag
    wr(8'h40, 4'h1, 32'h68);
    e0 = edges;
    repeat (150) @(posedge clk_i);
    chk(edges > e0, 1'b1);
    rdr(8'h40); chk(rd[7], 1'b1);
    wr(8'h48, 4'h1, 32'h04);
    cap_lvl[1] <= 1'b1;
    repeat (8) @(posedge clk_i);
    rdr(8'h48); chk(rd[7], 1'b1);
    wr(8'h48, 4'h1, 32'h04);
    cap_lvl[1] <= 1'b0;
    repeat (8) @(posedge clk_i);
    rdr(8'h48); chk(rd[7], 1'b0);
    // falling select: a rising pin must not flag, the fall must
    wr(8'h48, 4'h1, 32'h08);
    cap_lvl[1] <= 1'b1;
    repeat (8) @(posedge clk_i);
    rdr(8'h48); chk(rd[7], 1'b0);
    cap_lvl[1] <= 1'b0;
    repeat (8) @(posedge clk_i);
    rdr(8'h48); chk(rd[7], 1'b1);
  endtask

  // up/down counting: never above modulo, and a real downward step seen
  task automatic t_center;
    logic [31:0] p;
    logic [31:0] mx;
    logic        down;
    int          e0;
    mx = 32'h0;
    down = 1'b0;
    wr(`TPS_OFS_SC, 4'h1, 32'h00);
    wr(`TPS_OFS_CNT, 4'h1, 32'h0);
    wr(`TPS_OFS_MOD, 4'h3, 32'h10);
    // clear a stale overflow flag so the later check means something
    rdr(`TPS_OFS_SC);
    wr(`TPS_OFS_SC, 4'h1, 32'h00);
    rdr(`TPS_OFS_SC); chk(rd[7], 1'b0);
    wr(8'h44, 4'h3, 32'h08);
    rdr(8'h40);
    wr(8'h40, 4'h1, 32'h54);
    e0 = edges;
    wr(`TPS_OFS_SC, 4'h1, 32'h28);
    rdr(`TPS_OFS_CNT); p = rd;
    for (int i = 0; i < 40; i++) begin
      rdr(`TPS_OFS_CNT);
      if (rd > mx) mx = rd;
      if (rd < p && rd >= 4) down = 1'b1;
      p = rd;
    end
    chk(mx <= 32'h10, 1'b1);
    chk(down, 1'b1);
    chk(edges > e0, 1'b1);
    rdr(8'h40); chk(rd[7], 1'b1);
    rdr(`TPS_OFS_SC); chk(rd[7], 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_overflow();
    t_clocks();
    t_modbyte();
    t_count_debug();
    t_channels();
    t_center();
    wrap_up();
  end
endmodule
